// File: src/gpio_port_function_select.sv
// Overview of operation
// RQ1: Six bidirectional pins, one port, each muxable.
// RQ2: Function select register resets to all zeros.
// RQ3: Pins hold their driven level during power-down.
// RQ4: Bit 0 routes pin 0 as SPI select.
// RQ5: Bit 4 routes pin 1 as SPI clock.
// RQ6: Bit 8 routes pin 2 as SPI MISO.
// RQ7: Bit 12 routes pin 3 as SPI MOSI.
// RQ8: Bit 16 routes pin 4 as LIN receive.
// RQ9: Bit 20 routes pin 5 as LIN transmit.
// RQ10: Software writes zero to unused select bits.
// RQ11: Data register holds direction, output, input levels.
// RQ12: Set register ones drive pins high, zeros ignored.
// RQ13: Selected peripheral alone controls pin drive and value.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_function_select
  import port_mux_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic power_down,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  output logic spi_ss_in,
  output logic spi_sclk_in,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_drive,
  output logic spi_miso_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_drive,
  output logic spi_mosi_in,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_drive,
  output logic lin_test_receive,
  input wire logic lin_test_transmit
);

  logic [31:0] func_select_reg;
  logic [PINS-1:0] dir_reg;
  logic [PINS-1:0] dir_next;
  logic [PINS-1:0] out_reg;
  logic [PINS-1:0] out_next;
  logic [PINS-1:0] pad_out_reg;
  logic [PINS-1:0] pad_en_reg;
  logic [31:0] rdata_reg;

  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] alt_sel;
  logic [PINS-1:0] alt_out;
  logic [PINS-1:0] alt_en;
  logic [PINS-1:0] drive_out;
  logic [PINS-1:0] drive_en;
  logic spi_ss_next;
  logic spi_ss_reg;
  logic spi_sclk_next;
  logic spi_sclk_reg;
  logic spi_miso_next;
  logic spi_miso_reg;
  logic spi_mosi_next;
  logic spi_mosi_reg;
  logic lin_rx_next;
  logic lin_rx_reg;

  // Register decode
  logic hit_func;
  logic hit_data;
  logic hit_set;
  logic hit_clear;
  logic wr_func;
  logic wr_data;
  logic wr_set;
  logic wr_clear;
  logic [PINS-1:0] wdata_dir;
  logic [PINS-1:0] wdata_out;
  logic [31:0] data_view;
  logic [31:0] read_value;

  assign hit_func = (addr == FUNC_SELECT_ADDR);
  assign hit_data = (addr == DIR_LEVEL_ADDR);
  assign hit_set = (addr == BIT_SET_ADDR);
  assign hit_clear = (addr == BIT_CLEAR_ADDR);
  assign wr_func = wr_en && hit_func;
  assign wr_data = wr_en && hit_data;
  assign wr_set = wr_en && hit_set;
  assign wr_clear = wr_en && hit_clear;
  assign wdata_dir = wdata[DIR_LSB +: PINS];
  assign wdata_out = wdata[OUT_LSB +: PINS];

  // Direction and output latch; set and clear touch only the ones written
  assign dir_next = wr_data ? wdata_dir : dir_reg; // [RQ11]
  assign out_next = wr_data ? wdata_out : // [RQ11]
                    wr_set ? (out_reg | wdata_out) : // [RQ12]
                    wr_clear ? (out_reg & ~wdata_out) :
                    out_reg;

  // Reserved bits are masked off so a careless write cannot leave stray state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      func_select_reg <= FUNC_SELECT_RESET; // [RQ2]
    end else if (wr_func) begin
      func_select_reg <= wdata & FUNC_SELECT_MASK; // [RQ10]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_reg <= DIR_RESET;
      out_reg <= OUT_RESET;
    end else begin
      dir_reg <= dir_next;
      out_reg <= out_next;
    end
  end

  // Read path; write-only and unmapped addresses read zero
  always_comb begin
    data_view = 32'h0000_0000;
    data_view[DIR_LSB +: PINS] = dir_reg;
    data_view[OUT_LSB +: PINS] = out_reg;
    data_view[IN_LSB +: PINS] = pin_level; // [RQ11]
  end

  assign read_value = hit_func ? func_select_reg :
                      hit_data ? data_view :
                      32'h0000_0000;

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_reg <= read_value;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;

  // Pin input conditioning, one filter per pin
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
      pin_input_filter #(
        .RESET_LEVEL(PAD_LEVEL_RESET)
      ) u_filter (
        .clk(clk),
        .rst(rst),
        .pad_in(pin_in[gi]),
        .level(pin_level[gi])
      ); // [RQ1]
      assign alt_sel[gi] = func_select_reg[gi * FSEL_STRIDE];
      // Alternate function overrides port direction and output latch
      assign drive_out[gi] = alt_sel[gi] ? alt_out[gi] : out_reg[gi]; // [RQ13]
      assign drive_en[gi] = alt_sel[gi] ? alt_en[gi] : dir_reg[gi]; // [RQ13]
    end
  endgenerate

  // Per-pin alternate routing
  assign alt_out[PIN_SS] = 1'b0; // [RQ4]
  assign alt_en[PIN_SS] = 1'b0; // [RQ4]
  assign spi_ss_next = alt_sel[PIN_SS] ? pin_level[PIN_SS] : PERIPH_IN_IDLE[PIN_SS]; // [RQ4]

  assign alt_out[PIN_SCLK] = spi_sclk_out; // [RQ5]
  assign alt_en[PIN_SCLK] = spi_sclk_drive; // [RQ5]
  assign spi_sclk_next = alt_sel[PIN_SCLK] ? pin_level[PIN_SCLK] : PERIPH_IN_IDLE[PIN_SCLK]; // [RQ5]

  assign alt_out[PIN_MISO] = spi_miso_out; // [RQ6]
  assign alt_en[PIN_MISO] = spi_miso_drive; // [RQ6]
  assign spi_miso_next = alt_sel[PIN_MISO] ? pin_level[PIN_MISO] : PERIPH_IN_IDLE[PIN_MISO]; // [RQ6]

  assign alt_out[PIN_MOSI] = spi_mosi_out; // [RQ7]
  assign alt_en[PIN_MOSI] = spi_mosi_drive; // [RQ7]
  assign spi_mosi_next = alt_sel[PIN_MOSI] ? pin_level[PIN_MOSI] : PERIPH_IN_IDLE[PIN_MOSI]; // [RQ7]

  // Deselected LIN receive idles recessive
  assign alt_out[PIN_LIN_RX] = 1'b0; // [RQ8]
  assign alt_en[PIN_LIN_RX] = 1'b0; // [RQ8]
  assign lin_rx_next = alt_sel[PIN_LIN_RX] ? pin_level[PIN_LIN_RX] : PERIPH_IN_IDLE[PIN_LIN_RX]; // [RQ8]

  assign alt_out[PIN_LIN_TX] = lin_test_transmit; // [RQ9]
  assign alt_en[PIN_LIN_TX] = 1'b1; // [RQ9]

  // Peripheral inputs leave through a flop so a select write cannot glitch them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_ss_reg <= PERIPH_IN_IDLE[PIN_SS];
      spi_sclk_reg <= PERIPH_IN_IDLE[PIN_SCLK];
      spi_miso_reg <= PERIPH_IN_IDLE[PIN_MISO];
      spi_mosi_reg <= PERIPH_IN_IDLE[PIN_MOSI];
      lin_rx_reg <= PERIPH_IN_IDLE[PIN_LIN_RX];
    end else begin
      spi_ss_reg <= spi_ss_next;
      spi_sclk_reg <= spi_sclk_next;
      spi_miso_reg <= spi_miso_next;
      spi_mosi_reg <= spi_mosi_next;
      lin_rx_reg <= lin_rx_next;
    end
  end

  assign spi_ss_in = spi_ss_reg;
  assign spi_sclk_in = spi_sclk_reg;
  assign spi_miso_in = spi_miso_reg;
  assign spi_mosi_in = spi_mosi_reg;
  assign lin_test_receive = lin_rx_reg;

  // Pad drive is frozen in power-down so the board sees no glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_reg <= OUT_RESET;
      pad_en_reg <= DIR_RESET;
    end else if (!power_down) begin
      pad_out_reg <= drive_out;
      pad_en_reg <= drive_en;
    end // [RQ3]
  end

  assign pin_out = pad_out_reg;
  assign pin_oe_n = ~pad_en_reg;

endmodule

`default_nettype wire

// File: src/port_mux_pkg.sv
package port_mux_pkg;

  localparam int PIN_COUNT = 6;
  localparam int SYNC_STAGES = 3;

  localparam logic [31:0] FUNC_SELECT_ADDR = 32'hffff_0d00;
  localparam logic [31:0] DIR_LEVEL_ADDR = 32'hffff_0d10;
  localparam logic [31:0] BIT_SET_ADDR = 32'hffff_0d14;
  localparam logic [31:0] BIT_CLEAR_ADDR = 32'hffff_0d18;

  localparam int FSEL_STRIDE = 4;
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int IN_LSB = 0;

  localparam logic [31:0] FUNC_SELECT_RESET = 32'h0000_0000;
  localparam logic [31:0] FUNC_SELECT_MASK = 32'h0011_1111;
  localparam logic [5:0] DIR_RESET = 6'h00;
  localparam logic [5:0] OUT_RESET = 6'h00;
  localparam logic PAD_LEVEL_RESET = 1'b1;
  localparam logic [5:0] PERIPH_IN_IDLE = 6'h11;

  localparam int PIN_SS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_MOSI = 3;
  localparam int PIN_LIN_RX = 4;
  localparam int PIN_LIN_TX = 5;

endpackage

// File: src/pin_input_filter.sv
`timescale 1ns/1ps
`default_nettype none

module pin_input_filter
  import port_mux_pkg::*;
#(
  parameter logic RESET_LEVEL = PAD_LEVEL_RESET
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pad_in,
  output logic level
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;
  logic agree;

  // Only the second stage looks at stage1; a change counts once stages 2 and 3 agree
  assign agree = (stage2_reg == stage3_reg);
  assign level = level_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
      level_reg <= RESET_LEVEL;
    end else begin
      stage1_reg <= pad_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (agree) begin
        level_reg <= stage3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// File: verification/pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe_n,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pin_in
);
  // Pull-up wins where nobody drives; the device wins a clash
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (~ext_en | ext_val));
endmodule
`default_nettype wire

// File: verification/gpio_port_function_select_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_checker
  import port_mux_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic power_down,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic spi_ss_in,
  input wire logic spi_sclk_drive,
  input wire logic lin_test_receive,
  input wire logic lin_test_transmit
);
  logic [31:0] sel_reg;
  wire rd_sel = rd_en && addr == FUNC_SELECT_ADDR;
  wire rd_none = rd_en && addr != FUNC_SELECT_ADDR && addr != DIR_LEVEL_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the select register, so routing is judged from the bus alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sel_reg <= FUNC_SELECT_RESET;
    else if (wr_en && addr == FUNC_SELECT_ADDR) sel_reg <= wdata & FUNC_SELECT_MASK;
  end
  idle_read_a: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
    else $error("idle rdata");
  sel_read_a: assert property ($past(rd_sel) |-> rdata == sel_reg)
    else $error("select readback");
  none_read_a: assert property ($past(rd_none) |-> rdata == 32'h0000_0000)
    else $error("refused read");
  pad_hold_a: assert property ($past(power_down) |-> $stable(pin_out) && $stable(pin_oe_n))
    else $error("pad moved");
  ss_idle_a: assert property (!$past(sel_reg[0]) |-> spi_ss_in)
    else $error("select idle");
  rx_idle_a: assert property (!$past(sel_reg[16]) |-> lin_test_receive)
    else $error("receive idle");
  sclk_drive_a:
    assert property (!$past(power_down) && $past(sel_reg[4]) |-> pin_oe_n[1] != $past(spi_sclk_drive))
    else $error("clock drive");
  tx_route_a:
    assert property (!$past(power_down) && $past(sel_reg[20]) |-> !pin_oe_n[5] && pin_out[5] == $past(lin_test_transmit))
    else $error("transmit route");
  cover property ($past(rd_sel));
  cover property (power_down && sel_reg[20]);
  cover property (!spi_ss_in);
endmodule
bind gpio_port_function_select gpio_checker #(.PINS(PINS)) gpio_checker_inst (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_down(power_down), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .spi_ss_in(spi_ss_in), .spi_sclk_drive(spi_sclk_drive), .lin_test_receive(lin_test_receive),
  .lin_test_transmit(lin_test_transmit));
`default_nettype wire

// File: verification/gpio_port_function_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_port_function_select_test
  import port_mux_pkg::*;
;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, power_down = 0;
  logic [31:0] addr = 32'h0000_0000, wdata = 32'h0000_0000, rdata;
  logic [5:0] pin_in, pin_out, pin_oe_n, ext_en = 6'h00, ext_val = 6'h00;
  logic spi_ss_in, spi_sclk_in, spi_miso_in, spi_mosi_in, lin_test_receive;
  logic [6:0] spi = 7'h00;
  int n_fail = 0, checked = 0;
  wire [31:0] ins = {27'h0, lin_test_receive, spi_mosi_in, spi_miso_in, spi_sclk_in, spi_ss_in};
  gpio_port_function_select gpio_port_function_select_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .power_down(power_down), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .spi_ss_in(spi_ss_in), .spi_sclk_in(spi_sclk_in), .spi_sclk_out(spi[0]),
    .spi_sclk_drive(spi[1]), .spi_miso_in(spi_miso_in), .spi_miso_out(spi[2]), .spi_miso_drive(spi[3]),
    .spi_mosi_in(spi_mosi_in), .spi_mosi_out(spi[4]), .spi_mosi_drive(spi[5]), .lin_test_receive(lin_test_receive),
    .lin_test_transmit(spi[6]));
  pad_model pad_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pad(input logic [5:0] oe, m, v);
    chk({26'h0, pin_oe_n}, {26'h0, oe});
    chk({26'h0, pin_out & m}, {26'h0, v});
  endtask
  // One strobe cycle; a read also compares the word that follows
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 0;
    rd_en <= 0;
    #1;
    if (!w) chk(rdata, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1;
    ext_en <= 6'h00;
    repeat (16) @(posedge clk);
    rst <= 0;
  endtask
  task automatic t_reset;
    wt(4);
    pad(6'h3f, 6'h3f, 6'h00);
    chk(ins, 32'h0000_0011);
    bus(0, FUNC_SELECT_ADDR, 32'h0000_0000);
    bus(0, DIR_LEVEL_ADDR, 32'h0000_003f);
    $display("reset test done");
  endtask
  task automatic t_port;
    bus(1, DIR_LEVEL_ADDR, 32'h3f15_0000);
    wt(1);
    pad(6'h00, 6'h3f, 6'h15);
    bus(1, BIT_SET_ADDR, 32'h002a_0000);
    wt(1);
    pad(6'h00, 6'h3f, 6'h3f);
    bus(1, BIT_CLEAR_ADDR, 32'h0003_0000);
    wt(5);
    bus(0, DIR_LEVEL_ADDR, 32'h3f3c_003c);
    $display("port test done");
  endtask
  task automatic t_alt;
    @(posedge clk);
    spi <= 7'h27;
    bus(1, FUNC_SELECT_ADDR, 32'h0011_1111);
    bus(0, FUNC_SELECT_ADDR, 32'h0011_1111);
    wt(1);
    pad(6'h15, 6'h2a, 6'h02);
    @(posedge clk);
    power_down <= 1;
    spi <= 7'h48;
    wt(3);
    pad(6'h15, 6'h2a, 6'h02);
    @(posedge clk);
    power_down <= 0;
    ext_en <= 6'h1f;
    ext_val <= 6'h0e;
    wt(6);
    pad(6'h1b, 6'h24, 6'h20);
    chk(ins, 32'h0000_000a);
    bus(0, DIR_LEVEL_ADDR, 32'h3f3c_002a);
    bus(0, 32'hffff_0d04, 32'h0000_0000);
    bus(1, FUNC_SELECT_ADDR, 32'h0000_0000);
    wt(1);
    chk(ins, 32'h0000_0011);
    $display("alt test done");
  endtask
  task automatic conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset;
    t_reset;
    t_port;
    t_alt;
    do_reset;
    t_reset;
    conclude;
  end
  initial begin
    #100us;
    n_fail++;
    conclude;
  end
endmodule
`default_nettype wire
